// *** logic/nath_header_rewrite.sv ***
// NAT header rewrite datapath: entry table, match, field rewrite and MAC swap
// What this block does
// - WAN, inverse clear: compare destination IP with public IP; replace with private.
// - WAN, inverse clear: compare destination port with public port.
// - WAN, inverse set: compare source IP with public IP; replace with private.
// - LAN, inverse clear: compare source IP with private IP; replace with public.
// - LAN, inverse set: compare destination IP with private IP; replace with public.
// - LAN: source port (or destination when inverse) matched to private, replaced by public.
// - On a hit the egress port MAC is substituted in hardware.
// - MAC split: four bytes upper register, two bytes in lower bits 31:16.
// - Upper MAC register holds the first byte in bits 31:24, descending.
// - IP registers hold IPv4 address, most significant byte in 31:24.
// - Port registers hold port in bits 15:0, upper bits reserved.
// - Sixteen entries, each public IP, public port, private IP, private port.
// - LAN hit goes to WAN with source IP and port set public.
// - WAN hit: destination IP and port set private, forwarded to LAN.
// - Enables act only while entry enabled; disabled entry never hits.
// - Discard option flags a hit packet with drop; the header is still passed on for the drain side to throw away.
// - Nop with discard clear: packet received normally, nop flag reported.
`timescale 1ns/100ps
module nath_header_rewrite (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire nath_pkg::nath_reg_req_t reg_req,
    output logic [31:0] reg_rdata,
    input wire logic pkt_valid,
    input wire nath_pkg::nath_hdr_t pkt_hdr,
    output logic pkt_ready,
    output logic out_valid,
    output nath_pkg::nath_hdr_t out_hdr,
    output nath_pkg::nath_res_t out_res,
    input wire logic out_ready
);
    import nath_pkg::*;

    // Only the second flop feeds the logic, so all state leaves reset on one edge
    logic rst_sync_a;
    logic rst_sync_n;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_a <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_sync_a <= 1'b1;
            rst_sync_n <= rst_sync_a;
        end
    end

    // Entry table and port MACs
    nath_cfg_t cfg [NATH_ENTRIES];
    logic [31:0] public_ip_reg [NATH_ENTRIES];
    logic [15:0] public_port_reg [NATH_ENTRIES];
    logic [31:0] private_ip_reg [NATH_ENTRIES];
    logic [15:0] private_port_reg [NATH_ENTRIES];
    logic [31:0] wan_mac_upper;
    logic [15:0] wan_mac_lower;
    logic [31:0] lan_mac_upper;
    logic [15:0] lan_mac_lower;
    logic [NATH_CNT_W-1:0] hit_count;
    logic [NATH_CNT_W-1:0] drop_count;
    logic [NATH_IDX_W-1:0] last_entry;
    logic last_hit;

    nath_cfg_t next_cfg [NATH_ENTRIES];
    logic [31:0] next_public_ip_reg [NATH_ENTRIES];
    logic [15:0] next_public_port_reg [NATH_ENTRIES];
    logic [31:0] next_private_ip_reg [NATH_ENTRIES];
    logic [15:0] next_private_port_reg [NATH_ENTRIES];
    logic [31:0] next_wan_mac_upper;
    logic [15:0] next_wan_mac_lower;
    logic [31:0] next_lan_mac_upper;
    logic [15:0] next_lan_mac_lower;
    logic [31:0] next_reg_rdata;

    logic [NATH_ADDR_W-1:0] tbl_base;
    logic [NATH_IDX_W-1:0] tbl_idx;

    assign tbl_base = reg_req.addr & NATH_TABLE_MASK;
    assign tbl_idx = reg_req.addr[NATH_WORD_LSB +: NATH_IDX_W];

    // Status word: read-only, counters wrap and are cleared only by reset
    logic [31:0] status_word;

    always_comb begin
        status_word = NATH_ZERO_WORD;
        status_word[NATH_STAT_CNT_LSB +: NATH_CNT_W] = hit_count;
        status_word[NATH_STAT_IDX_LSB + NATH_IDX_W] = last_hit;
        status_word[NATH_STAT_IDX_LSB +: NATH_IDX_W] = last_entry;
        status_word[NATH_STAT_IDX_LSB-1:0] = drop_count[NATH_STAT_IDX_LSB-1:0];
    end

    always_comb begin
        for (int i = 0; i < NATH_ENTRIES; i++) begin
            next_cfg[i] = cfg[i];
            next_public_ip_reg[i] = public_ip_reg[i];
            next_public_port_reg[i] = public_port_reg[i];
            next_private_ip_reg[i] = private_ip_reg[i];
            next_private_port_reg[i] = private_port_reg[i];
        end
        next_wan_mac_upper = wan_mac_upper;
        next_wan_mac_lower = wan_mac_lower;
        next_lan_mac_upper = lan_mac_upper;
        next_lan_mac_lower = lan_mac_lower;
        if (reg_req.wr) begin
            case (tbl_base)
                NATH_CFG_BASE: next_cfg[tbl_idx] = reg_req.wdata[NATH_CFG_W-1:0];
                NATH_PUB_IP_BASE: next_public_ip_reg[tbl_idx] = reg_req.wdata;
                NATH_PUB_PORT_BASE: next_public_port_reg[tbl_idx] = reg_req.wdata[NATH_PORT_W-1:0];
                NATH_PRIV_IP_BASE: next_private_ip_reg[tbl_idx] = reg_req.wdata;
                NATH_PRIV_PORT_BASE: next_private_port_reg[tbl_idx] = reg_req.wdata[NATH_PORT_W-1:0];
                default: begin
                    case (reg_req.addr)
                        NATH_WAN_MAC_UPPER: next_wan_mac_upper = reg_req.wdata;
                        NATH_WAN_MAC_LOWER: next_wan_mac_lower = reg_req.wdata[31:NATH_MAC_LOWER_LSB];
                        NATH_LAN_MAC_UPPER: next_lan_mac_upper = reg_req.wdata;
                        NATH_LAN_MAC_LOWER: next_lan_mac_lower = reg_req.wdata[31:NATH_MAC_LOWER_LSB];
                        default: ;
                    endcase
                end
            endcase
        end
    end

    // Read data, one cycle after the strobe; unmapped reads give zero
    always_comb begin
        next_reg_rdata = NATH_ZERO_WORD;
        if (reg_req.rd) begin
            case (tbl_base)
                NATH_CFG_BASE: next_reg_rdata = {{(32-NATH_CFG_W){1'b0}}, cfg[tbl_idx]};
                NATH_PUB_IP_BASE: next_reg_rdata = public_ip_reg[tbl_idx];
                NATH_PUB_PORT_BASE: next_reg_rdata = {16'h0000, public_port_reg[tbl_idx]};
                NATH_PRIV_IP_BASE: next_reg_rdata = private_ip_reg[tbl_idx];
                NATH_PRIV_PORT_BASE: next_reg_rdata = {16'h0000, private_port_reg[tbl_idx]};
                default: begin
                    case (reg_req.addr)
                        NATH_WAN_MAC_UPPER: next_reg_rdata = wan_mac_upper;
                        NATH_WAN_MAC_LOWER: next_reg_rdata = {wan_mac_lower, 16'h0000};
                        NATH_LAN_MAC_UPPER: next_reg_rdata = lan_mac_upper;
                        NATH_LAN_MAC_LOWER: next_reg_rdata = {lan_mac_lower, 16'h0000};
                        NATH_STATUS: next_reg_rdata = status_word;
                        default: next_reg_rdata = NATH_ZERO_WORD;
                    endcase
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            for (int i = 0; i < NATH_ENTRIES; i++) begin
                cfg[i] <= '0;
                public_ip_reg[i] <= '0;
                public_port_reg[i] <= '0;
                private_ip_reg[i] <= '0;
                private_port_reg[i] <= '0;
            end
            wan_mac_upper <= '0;
            wan_mac_lower <= '0;
            lan_mac_upper <= '0;
            lan_mac_lower <= '0;
            reg_rdata <= '0;
        end else begin
            for (int i = 0; i < NATH_ENTRIES; i++) begin
                cfg[i] <= next_cfg[i];
                public_ip_reg[i] <= next_public_ip_reg[i];
                public_port_reg[i] <= next_public_port_reg[i];
                private_ip_reg[i] <= next_private_ip_reg[i];
                private_port_reg[i] <= next_private_port_reg[i];
            end
            wan_mac_upper <= next_wan_mac_upper;
            wan_mac_lower <= next_wan_mac_lower;
            lan_mac_upper <= next_lan_mac_upper;
            lan_mac_lower <= next_lan_mac_lower;
            reg_rdata <= next_reg_rdata;
        end
    end

    // Per-entry match. Source fields are used on WAN with inverse, or LAN without.
    logic [NATH_ENTRIES-1:0] entry_hit;
    logic [NATH_ENTRIES-1:0] use_src;

    for (genvar g = 0; g < NATH_ENTRIES; g++) begin : g_match
        logic [31:0] pkt_ip;
        logic [15:0] pkt_port;
        logic [31:0] cmp_ip;
        logic [15:0] cmp_port;
        logic ip_ok;
        logic port_ok;
        assign use_src[g] = pkt_hdr.from_wan ? cfg[g].inverse : !cfg[g].inverse;
        assign pkt_ip = use_src[g] ? pkt_hdr.source_ip_field : pkt_hdr.dest_ip_field;
        assign pkt_port = use_src[g] ? pkt_hdr.source_port_field : pkt_hdr.dest_port_field;
        assign cmp_ip = pkt_hdr.from_wan ? public_ip_reg[g] : private_ip_reg[g];
        assign cmp_port = pkt_hdr.from_wan ? public_port_reg[g] : private_port_reg[g];
        assign ip_ok = !cfg[g].ip_compare_enable || (pkt_ip == cmp_ip);
        assign port_ok = !cfg[g].port_compare_enable || (pkt_port == cmp_port);
        // No comparison enabled means nothing to match against, so no hit
        assign entry_hit[g] = cfg[g].entry_enable && ip_ok && port_ok
            && (cfg[g].ip_compare_enable || cfg[g].port_compare_enable);
    end

    // Lowest numbered hit wins, then rewrite
    nath_hdr_t next_out_hdr;
    nath_res_t next_out_res;
    logic next_out_valid;
    logic [NATH_CNT_W-1:0] next_hit_count;
    logic [NATH_CNT_W-1:0] next_drop_count;
    logic [NATH_IDX_W-1:0] next_last_entry;
    logic next_last_hit;
    logic take;
    logic sel_found;
    logic [NATH_IDX_W-1:0] sel;
    nath_cfg_t sc;

    // Stage holds one header; it takes a new one only when empty or when the drain side accepts
    assign pkt_ready = !out_valid || out_ready;
    assign take = pkt_valid && pkt_ready;

    always_comb begin
        sel_found = 1'b0;
        sel = '0;
        for (int i = NATH_ENTRIES - 1; i >= 0; i--) begin
            if (entry_hit[i]) begin
                sel_found = 1'b1;
                sel = NATH_IDX_W'(i);
            end
        end
        sc = cfg[sel];
        next_out_valid = out_valid;
        next_out_hdr = out_hdr;
        next_out_res = out_res;
        next_hit_count = hit_count;
        next_drop_count = drop_count;
        next_last_entry = last_entry;
        next_last_hit = last_hit;
        if (out_valid && out_ready) begin
            next_out_valid = 1'b0;
        end
        if (take) begin
            next_out_valid = 1'b1;
            next_out_hdr = pkt_hdr;
            next_out_res = '0;
            next_last_hit = sel_found;
            if (sel_found) begin
                next_out_res.hit = 1'b1;
                next_out_res.entry = sel;
                // Drop is only reported; the drain side must throw the header away
                next_out_res.drop = sc.discard;
                next_out_res.nop = sc.nop && !sc.discard;
                next_last_entry = sel;
                next_hit_count = hit_count + NATH_CNT_ONE;
                if (sc.discard) begin
                    next_drop_count = drop_count + NATH_CNT_ONE;
                end
                // Replace enables are not gated by compare enables; software pairs them
                if (pkt_hdr.from_wan) begin
                    // WAN to LAN: fields become private, LAN MAC as sender
                    if (sc.ip_replace_enable && use_src[sel]) begin
                        next_out_hdr.source_ip_field = private_ip_reg[sel];
                    end else if (sc.ip_replace_enable) begin
                        next_out_hdr.dest_ip_field = private_ip_reg[sel];
                    end
                    if (sc.port_replace_enable && use_src[sel]) begin
                        next_out_hdr.source_port_field = private_port_reg[sel];
                    end else if (sc.port_replace_enable) begin
                        next_out_hdr.dest_port_field = private_port_reg[sel];
                    end
                    next_out_hdr.src_mac = {lan_mac_upper, lan_mac_lower};
                end else begin
                    // LAN to WAN: fields become public, WAN MAC as sender
                    if (sc.ip_replace_enable && use_src[sel]) begin
                        next_out_hdr.source_ip_field = public_ip_reg[sel];
                    end else if (sc.ip_replace_enable) begin
                        next_out_hdr.dest_ip_field = public_ip_reg[sel];
                    end
                    if (sc.port_replace_enable && use_src[sel]) begin
                        next_out_hdr.source_port_field = public_port_reg[sel];
                    end else if (sc.port_replace_enable) begin
                        next_out_hdr.dest_port_field = public_port_reg[sel];
                    end
                    next_out_hdr.src_mac = {wan_mac_upper, wan_mac_lower};
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            out_valid <= 1'b0;
            out_hdr <= '0;
            out_res <= '0;
            hit_count <= '0;
            drop_count <= '0;
            last_entry <= '0;
            last_hit <= 1'b0;
        end else begin
            out_valid <= next_out_valid;
            out_hdr <= next_out_hdr;
            out_res <= next_out_res;
            hit_count <= next_hit_count;
            drop_count <= next_drop_count;
            last_entry <= next_last_entry;
            last_hit <= next_last_hit;
        end
    end
endmodule

// *** logic/nath_pkg.sv ***
// Constants, register map and carrier types of the NAT header rewrite block
package nath_pkg;
    localparam int NATH_ENTRIES = 16;
    localparam int NATH_IDX_W = 4;
    localparam int NATH_ADDR_W = 10;
    localparam int NATH_CNT_W = 16;

    // Register map, byte addresses, one 32-bit word per register
    localparam logic [NATH_ADDR_W-1:0] NATH_CFG_BASE = 10'h100;
    localparam logic [NATH_ADDR_W-1:0] NATH_PUB_IP_BASE = 10'h140;
    localparam logic [NATH_ADDR_W-1:0] NATH_PUB_PORT_BASE = 10'h180;
    localparam logic [NATH_ADDR_W-1:0] NATH_PRIV_IP_BASE = 10'h1c0;
    localparam logic [NATH_ADDR_W-1:0] NATH_PRIV_PORT_BASE = 10'h200;
    localparam logic [NATH_ADDR_W-1:0] NATH_WAN_MAC_UPPER = 10'h240;
    localparam logic [NATH_ADDR_W-1:0] NATH_WAN_MAC_LOWER = 10'h244;
    localparam logic [NATH_ADDR_W-1:0] NATH_LAN_MAC_UPPER = 10'h248;
    localparam logic [NATH_ADDR_W-1:0] NATH_LAN_MAC_LOWER = 10'h24c;
    localparam logic [NATH_ADDR_W-1:0] NATH_STATUS = 10'h250;
    localparam logic [NATH_ADDR_W-1:0] NATH_TABLE_MASK = 10'h3c0;
    localparam int NATH_WORD_LSB = 2;

    // Entry configuration bit positions
    localparam int NATH_CFG_EN = 0;
    localparam int NATH_CFG_ACE = 1;
    localparam int NATH_CFG_PCE = 2;
    localparam int NATH_CFG_ARE = 3;
    localparam int NATH_CFG_PRE = 4;
    localparam int NATH_CFG_INV = 5;
    localparam int NATH_CFG_DISCARD = 6;
    localparam int NATH_CFG_NOP = 7;
    localparam int NATH_CFG_W = 8;

    // Field layouts
    localparam int NATH_PORT_W = 16;
    localparam int NATH_MAC_LOWER_LSB = 16;
    localparam int NATH_MAC_SPLIT = 16;
    localparam int NATH_STAT_CNT_LSB = 16;
    localparam int NATH_STAT_IDX_LSB = 4;

    localparam logic [31:0] NATH_ZERO_WORD = 32'h0000_0000;
    localparam logic [NATH_CNT_W-1:0] NATH_CNT_ONE = 16'h0001;

    typedef struct packed {
        logic from_wan;
        logic [47:0] dst_mac;
        logic [47:0] src_mac;
        logic [31:0] source_ip_field;
        logic [31:0] dest_ip_field;
        logic [15:0] source_port_field;
        logic [15:0] dest_port_field;
    } nath_hdr_t;

    typedef struct packed {
        logic hit;
        logic [NATH_IDX_W-1:0] entry;
        logic drop;
        logic nop;
    } nath_res_t;

    typedef struct packed {
        logic nop;
        logic discard;
        logic inverse;
        logic port_replace_enable;
        logic ip_replace_enable;
        logic port_compare_enable;
        logic ip_compare_enable;
        logic entry_enable;
    } nath_cfg_t;

    typedef struct packed {
        logic [NATH_ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } nath_reg_req_t;
endpackage

// *** verif/nath_header_rewrite_properties.sv ***
// Port-level checker of the NAT header rewrite block
`timescale 1ns/100ps
module nath_header_rewrite_properties (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire nath_pkg::nath_reg_req_t reg_req,
    input wire logic [31:0] reg_rdata,
    input wire logic pkt_valid,
    input wire nath_pkg::nath_hdr_t pkt_hdr,
    input wire logic pkt_ready,
    input wire logic out_valid,
    input wire nath_pkg::nath_hdr_t out_hdr,
    input wire nath_pkg::nath_res_t out_res,
    input wire logic out_ready
);
    import nath_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    property p_ready_eq; pkt_ready == (!out_valid || out_ready); endproperty
    a_ready_eq: assert property (p_ready_eq) else $error("pkt_ready not tied to drain state");
    property p_take; pkt_valid && pkt_ready |=> out_valid; endproperty
    a_take: assert property (p_take) else $error("taken header gave no result");
    property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_hdr) && $stable(out_res); endproperty
    a_hold: assert property (p_hold) else $error("result changed while stalled");
    property p_miss_pass; pkt_valid && pkt_ready |=> out_res.hit || out_hdr == $past(pkt_hdr); endproperty
    a_miss_pass: assert property (p_miss_pass) else $error("missed header was altered");
    property p_dst_mac;
        pkt_valid && pkt_ready |=> out_hdr.dst_mac == $past(pkt_hdr.dst_mac)
            && out_hdr.from_wan == $past(pkt_hdr.from_wan);
    endproperty
    a_dst_mac: assert property (p_dst_mac) else $error("destination MAC or port flag altered");
    property p_opt_hit; out_valid && (out_res.drop || out_res.nop) |-> out_res.hit; endproperty
    a_opt_hit: assert property (p_opt_hit) else $error("drop or nop without hit");
    property p_nop_excl; out_valid |-> !(out_res.drop && out_res.nop); endproperty
    a_nop_excl: assert property (p_nop_excl) else $error("nop reported with drop");
    property p_rdata_idle; !reg_req.rd |=> reg_rdata == 32'h0; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
endmodule

bind nath_header_rewrite nath_header_rewrite_properties u_props (.core_clk(core_clk), .arst_n(arst_n),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .pkt_valid(pkt_valid), .pkt_hdr(pkt_hdr),
    .pkt_ready(pkt_ready), .out_valid(out_valid), .out_hdr(out_hdr), .out_res(out_res), .out_ready(out_ready));

// *** verif/nath_header_rewrite_tb.sv ***
// Self-checking testbench of the NAT header rewrite block
`timescale 1ns/100ps
module nath_header_rewrite_tb;
    import nath_pkg::*;
    localparam logic [31:0] PUB = 32'h8c700264;
    localparam logic [31:0] PRIV = 32'hc0a80105;
    localparam logic [31:0] XIP = 32'h01020304;
    localparam logic [15:0] PUBP = 16'h1d4c;
    localparam logic [15:0] PRIVP = 16'h0050;
    localparam logic [15:0] XP = 16'h1111;
    localparam logic [47:0] WMAC = 48'h123456789013;
    localparam logic [47:0] LMAC = 48'habcdef012345;
    localparam logic [47:0] SMAC = 48'h020000000001;
    logic core_clk, arst_n, stall, pkt_valid, pkt_ready, out_valid, out_ready;
    logic [31:0] reg_rdata;
    nath_reg_req_t reg_req;
    nath_hdr_t pkt_hdr, out_hdr;
    nath_res_t out_res;
    int fails = 0;
    int n_compared = 0;

    nath_header_rewrite uut (.core_clk(core_clk), .arst_n(arst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .pkt_valid(pkt_valid), .pkt_hdr(pkt_hdr), .pkt_ready(pkt_ready), .out_valid(out_valid),
        .out_hdr(out_hdr), .out_res(out_res), .out_ready(out_ready));
    nath_mac_port_model mac (.core_clk(core_clk), .stall(stall), .pkt_valid(pkt_valid), .pkt_hdr(pkt_hdr),
        .pkt_ready(pkt_ready), .out_valid(out_valid), .out_hdr(out_hdr), .out_res(out_res), .out_ready(out_ready));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic final_report;
        if (fails == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [199:0] got, input logic [199:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        reg_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        reg_req.rd <= 1'b0;
        #1 chk(200'(reg_rdata), 200'(exp));
    endtask
    function automatic nath_hdr_t mk(logic w, logic [31:0] si, logic [31:0] di, logic [15:0] sp,
            logic [15:0] dp, logic [47:0] sm);
        mk = '{w, 48'h0a0b0c0d0e0f, sm, si, di, sp, dp};
    endfunction
    // Entry 3 and entry 5 hold the same mapping, so the winner shows in the result
    task automatic run(input logic [7:0] c3, input logic [7:0] c5, input nath_hdr_t hi, input nath_hdr_t he,
            input nath_res_t re);
        int n;
        wr(NATH_CFG_BASE + 10'h00c, {24'h0, c3});
        wr(NATH_CFG_BASE + 10'h014, {24'h0, c5});
        mac.send(hi);
        n = 0;
        while (mac.q_hdr.size() == 0 && n < 50) begin
            @(posedge core_clk);
            n++;
        end
        chk(200'(mac.q_hdr.size()), 200'd1);
        chk(200'(mac.q_hdr.pop_front()), 200'(he));
        chk(200'(mac.q_res.pop_front()), 200'(re));
    endtask

    initial begin
        #100000;
        fails++;
        final_report();
    end

    initial begin
        arst_n = 1'b0;
        stall = 1'b0;
        reg_req = '0;
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        rd(NATH_CFG_BASE, 32'h0);
        wr(NATH_STATUS, 32'hffffffff);
        rd(NATH_STATUS, 32'h0);
        wr(10'h260, 32'hffffffff);
        rd(10'h260, 32'h0);
        wr(NATH_WAN_MAC_UPPER, WMAC[47:16]);
        wr(NATH_WAN_MAC_LOWER, {WMAC[15:0], 16'hffff});
        wr(NATH_LAN_MAC_UPPER, LMAC[47:16]);
        wr(NATH_LAN_MAC_LOWER, {LMAC[15:0], 16'h0000});
        rd(NATH_WAN_MAC_UPPER, 32'h12345678);
        rd(NATH_WAN_MAC_LOWER, 32'h90130000);
        for (int i = 3; i <= 5; i += 2) begin
            wr(NATH_PUB_IP_BASE + 10'(4 * i), PUB);
            wr(NATH_PUB_PORT_BASE + 10'(4 * i), {16'hffff, PUBP});
            wr(NATH_PRIV_IP_BASE + 10'(4 * i), PRIV);
            wr(NATH_PRIV_PORT_BASE + 10'(4 * i), {16'h0, PRIVP});
        end
        rd(NATH_PUB_IP_BASE + 10'h014, 32'h8c700264);
        rd(NATH_PUB_PORT_BASE + 10'h014, 32'h00001d4c);
        wr(NATH_PRIV_IP_BASE + 10'h03c, 32'h0a000001);
        rd(NATH_PRIV_IP_BASE + 10'h03c, 32'h0a000001);
        // Drain stalls on the first packet to hold the result
        stall <= 1'b1;
        fork
            run(8'h1f, 8'h1f, mk(1, XIP, PUB, XP, PUBP, SMAC), mk(1, XIP, PRIV, XP, PRIVP, LMAC),
                '{1'b1, 4'h3, 1'b0, 1'b0});
            begin
                repeat (12) @(posedge core_clk);
                stall <= 1'b0;
            end
        join
        run(8'h1f, 8'h00, mk(0, PRIV, XIP, PRIVP, XP, SMAC), mk(0, PUB, XIP, PUBP, XP, WMAC),
            '{1'b1, 4'h3, 1'b0, 1'b0});
        run(8'h2b, 8'h00, mk(1, PUB, XIP, XP, XP, SMAC), mk(1, PRIV, XIP, XP, XP, LMAC),
            '{1'b1, 4'h3, 1'b0, 1'b0});
        run(8'h3f, 8'h00, mk(0, XIP, PRIV, XP, PRIVP, SMAC), mk(0, XIP, PUB, XP, PUBP, WMAC),
            '{1'b1, 4'h3, 1'b0, 1'b0});
        run(8'h1e, 8'h1f, mk(1, XIP, PUB, XP, PUBP, SMAC), mk(1, XIP, PRIV, XP, PRIVP, LMAC),
            '{1'b1, 4'h5, 1'b0, 1'b0});
        run(8'h1f, 8'h00, mk(1, XIP, PUB, XP, XP, SMAC), mk(1, XIP, PUB, XP, XP, SMAC),
            '{1'b0, 4'h0, 1'b0, 1'b0});
        run(8'h5f, 8'h00, mk(1, XIP, PUB, XP, PUBP, SMAC), mk(1, XIP, PRIV, XP, PRIVP, LMAC),
            '{1'b1, 4'h3, 1'b1, 1'b0});
        run(8'h9f, 8'h00, mk(1, XIP, PUB, XP, PUBP, SMAC), mk(1, XIP, PRIV, XP, PRIVP, LMAC),
            '{1'b1, 4'h3, 1'b0, 1'b1});
        run(8'hdf, 8'h00, mk(1, XIP, PUB, XP, PUBP, SMAC), mk(1, XIP, PRIV, XP, PRIVP, LMAC),
            '{1'b1, 4'h3, 1'b1, 1'b0});
        // Eight hits, two dropped, last one a hit on entry 3
        rd(NATH_STATUS, 32'h00080132);
        final_report();
    end
endmodule

// *** verif/nath_mac_port_model.sv ***
// Ethernet MAC port model: feeds received headers and drains rewritten ones
`timescale 1ns/100ps
module nath_mac_port_model (
    input wire logic core_clk,
    input wire logic stall,
    output logic pkt_valid,
    output nath_pkg::nath_hdr_t pkt_hdr,
    input wire logic pkt_ready,
    input wire logic out_valid,
    input wire nath_pkg::nath_hdr_t out_hdr,
    input wire nath_pkg::nath_res_t out_res,
    output logic out_ready
);
    import nath_pkg::*;
    nath_hdr_t q_hdr[$];
    nath_res_t q_res[$];
    initial begin
        pkt_valid = 1'b0;
        pkt_hdr = '0;
    end
    assign out_ready = !stall;
    // Header held until the edge that takes it, then scrambled
    task automatic send(input nath_hdr_t h);
        @(posedge core_clk);
        pkt_valid <= 1'b1;
        pkt_hdr <= h;
        @(posedge core_clk);
        while (pkt_ready !== 1'b1) @(posedge core_clk);
        pkt_valid <= 1'b0;
        pkt_hdr <= ~h;
    endtask
    always @(posedge core_clk) begin
        if (out_valid === 1'b1 && out_ready === 1'b1) begin
            q_hdr.push_back(out_hdr);
            q_res.push_back(out_res);
        end
    end
endmodule
